// ### logic/cdo_pkg.sv
// constants shared by the coupler diagnostic and output image block
package cdo_pkg;

   // apb register byte offsets
   localparam logic [7:0] OFS_MODULE_FAULT_LED        = 8'h00;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h08;
   localparam logic [7:0] OFS_WARRANTY    = 8'h10;
   localparam logic [7:0] OFS_IMG_LEN     = 8'h14;
   localparam logic [7:0] OFS_SLOT_TYPE   = 8'h20;
   localparam logic [7:0] OFS_SLOT_DATA   = 8'h40;
   localparam logic [7:0] OFS_IMAGE       = 8'h80;
   localparam logic [1:0] WORD_ALIGN      = 2'h0;
   localparam int         ADDR_LSB        = 2;

   // low diagnostic byte field positions
   localparam int BIT_CFG_ERR      = 0;
   localparam int BIT_TIMEOUT      = 1;
   localparam int BIT_COMM_ERR     = 2;
   localparam int BIT_UNUSED       = 3;
   localparam int BIT_NO_MODULE    = 4;
   localparam int BIT_WARRANTY     = 5;
   localparam int BIT_MODULE_STATE = 6;
   localparam int BIT_COUPLER      = 7;

   localparam logic [7:0] MODULE_FAULT_LED_RESERVED_HI = 8'h00;
   localparam logic [7:0] EVENT_MASK       = 8'hf7;
   localparam logic [7:0] DO4_MASK         = 8'h0f;
   localparam logic [7:0] BYTE_ZERO        = 8'h00;

   // slot module kinds as written to a slot type register
   typedef enum logic [1:0] {
      CDO_SLOT_DO4,
      CDO_SLOT_DO8,
      CDO_SLOT_AO1,
      CDO_SLOT_AO2
   } cdo_slot_t;

   // bytes each kind contributes to the output image
   localparam int NB_DO  = 1;
   localparam int NB_AO1 = 2;
   localparam int NB_AO2 = 4;
   localparam int NB_MAX = 4;

   // operating time limit in counted units, three years
   localparam int WARRANTY_LIMIT = 157680;
   localparam int WARRANTY_W     = 18;

   // default sizes
   localparam int MAX_SLOTS_DEF = 8;
   localparam int IMG_BYTES_DEF = 16;
   localparam int CNT_W         = 4;

endpackage

// ### logic/cdo_warranty.sv
// operating time counter and warranty expiry flag
`timescale 1ns/1ps
`default_nettype none

module cdo_warranty #(
   parameter int LIMIT = cdo_pkg::WARRANTY_LIMIT
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          op_tick,
   output logic [cdo_pkg::WARRANTY_W-1:0]     op_count,
   output logic                               expired
);

   typedef struct packed {
      logic [cdo_pkg::WARRANTY_W-1:0] count;
      logic                           expired;
   } cdo_wst_t;

   localparam logic [cdo_pkg::WARRANTY_W-1:0] LIM  = cdo_pkg::WARRANTY_W'(LIMIT);
   localparam logic [cdo_pkg::WARRANTY_W-1:0] ONE  = cdo_pkg::WARRANTY_W'(1);

   cdo_wst_t st_ff;
   cdo_wst_t nxt_st;

   // count saturates one past the limit so the flag can never wrap back to 0
   always_comb begin
      nxt_st = st_ff;
      if (op_tick && (st_ff.count <= LIM)) begin
         nxt_st.count = st_ff.count + ONE;
      end
      // RULE_06 expiry past limit
      nxt_st.expired = (nxt_st.count > LIM);
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign op_count = st_ff.count;
   assign expired  = st_ff.expired;

endmodule

`default_nettype wire

// ### logic/cdo_top.sv
// coupler diagnostic word, output image packer and apb register bank
//
// Contract
// RULE_01 - output image packed per slot, analog high first
// RULE_02 - diagnostic word: reserved high, flags low, bit3 unused
// RULE_03 - bit0 flags any module configuration error
// RULE_04 - bit1 flags any module timeout cause
// RULE_05 - bit2 flags module bus communication error
// RULE_06 - bit5 set once operating count passes limit
// RULE_07 - bit6 module error, drives module fault led
// RULE_08 - bit7 coupler error, drives system led
// RULE_09 - bit4 set when no module connected
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cdo_top #(
   parameter int MAX_SLOTS      = cdo_pkg::MAX_SLOTS_DEF,
   parameter int IMG_BYTES      = cdo_pkg::IMG_BYTES_DEF,
   parameter int WARRANTY_LIMIT = cdo_pkg::WARRANTY_LIMIT
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic [cdo_pkg::CNT_W-1:0]  module_count,
   input  wire logic                       bad_arrangement,
   input  wire logic                       mod_detached,
   input  wire logic                       mod_noise_lost,
   input  wire logic                       mod_hot_swap,
   input  wire logic                       mod_op_error,
   input  wire logic                       replaced_mismatch,
   input  wire logic                       unknown_comm_error,
   input  wire logic                       module_state_error,
   input  wire logic                       coupler_init_error,
   input  wire logic                       network_conn_error,
   input  wire logic                       op_tick,
   input  wire logic [7:0]                 img_rd_index,
   output logic [7:0]                      img_rd_byte,
   output logic [7:0]                      img_len,
   output logic                            module_fault_led,
   output logic                            system_led,
   output logic                            irq
);

   localparam int IMG_WORDS = IMG_BYTES / 4;
   localparam logic [cdo_pkg::CNT_W-1:0] MAX_CNT = cdo_pkg::CNT_W'(MAX_SLOTS);

   typedef struct packed {
      logic [IMG_BYTES-1:0][7:0] image;
      logic [7:0]                len;
      logic                      over;
   } cdo_pack_t;

   typedef struct packed {
      logic                         pready;
      logic                         pslverr;
      logic [31:0]                  prdata;
      logic [7:0]                   module_fault_led_lo;
      logic [7:0]                   irq_status;
      logic [7:0]                   irq_mask;
      logic                         irq;
      logic                         mfault_led;
      logic                         sys_led;
      logic [7:0]                   img_rd_byte;
      logic [MAX_SLOTS-1:0][1:0]    slot_type;
      logic [MAX_SLOTS-1:0][31:0]   slot_data;
      logic [IMG_BYTES-1:0][7:0]    image;
      logic [7:0]                   img_len;
   } cdo_state_t;

   cdo_state_t                        st_ff;
   cdo_state_t                        nxt_st;
   cdo_pack_t                         pk;
   logic [cdo_pkg::WARRANTY_W-1:0]    op_count;
   logic                              warranty_expired;

   // true when addr falls in a word array of n entries at base
   function automatic logic in_region(input logic [7:0] addr, input logic [7:0] base,
                                      input int n);
      int unsigned off;
      off = int'(addr) - int'(base);
      return (addr >= base) && ((off >> cdo_pkg::ADDR_LSB) < n);
   endfunction

   // word index of addr within a region
   function automatic int region_index(input logic [7:0] addr, input logic [7:0] base);
      return (int'(addr) - int'(base)) >> cdo_pkg::ADDR_LSB;
   endfunction

   // walk the populated slots in order and append each module's bytes
   function automatic cdo_pack_t pack_image(input logic [MAX_SLOTS-1:0][1:0] ty,
                                            input logic [MAX_SLOTS-1:0][31:0] dat,
                                            input logic [cdo_pkg::CNT_W-1:0] cnt);
      cdo_pack_t                      r;
      int unsigned                    pos;
      int unsigned                    nb;
      logic [cdo_pkg::NB_MAX-1:0][7:0] bytes;
      r     = '0;
      pos   = 0;
      nb    = 0;
      bytes = '0;
      for (int s = 0; s < MAX_SLOTS; s++) begin
         if (s < int'(cnt)) begin
            bytes = '0;
            unique case (cdo_pkg::cdo_slot_t'(ty[s]))
               cdo_pkg::CDO_SLOT_DO4: begin
                  nb       = cdo_pkg::NB_DO;
                  bytes[0] = dat[s][7:0] & cdo_pkg::DO4_MASK;
               end
               cdo_pkg::CDO_SLOT_DO8: begin
                  nb       = cdo_pkg::NB_DO;
                  bytes[0] = dat[s][7:0];
               end
               cdo_pkg::CDO_SLOT_AO1: begin
                  nb       = cdo_pkg::NB_AO1;
                  bytes[0] = dat[s][15:8];
                  bytes[1] = dat[s][7:0];
               end
               cdo_pkg::CDO_SLOT_AO2: begin
                  nb       = cdo_pkg::NB_AO2;
                  bytes[0] = dat[s][15:8];
                  bytes[1] = dat[s][7:0];
                  bytes[2] = dat[s][31:24];
                  bytes[3] = dat[s][23:16];
               end
            endcase
            for (int b = 0; b < cdo_pkg::NB_MAX; b++) begin
               if (b < int'(nb)) begin
                  if (pos < IMG_BYTES) begin
                     r.image[pos] = bytes[b];
                  end else begin
                     r.over = 1'b1;
                  end
                  pos = pos + 1;
               end
            end
         end
      end
      r.len = 8'(pos);
      return r;
   endfunction

   cdo_warranty #(
      .LIMIT    (WARRANTY_LIMIT)
   ) u_warranty (
      .pclk     (pclk),
      .presetn  (presetn),
      .op_tick  (op_tick),
      .op_count (op_count),
      .expired  (warranty_expired)
   );

   // RULE_01 pack slot bytes
   always_comb begin
      pk = pack_image(st_ff.slot_type, st_ff.slot_data, module_count);
   end

   // next state: diagnostics, interrupts, apb slave, image
   always_comb begin
      logic        acc_first;
      logic        acc_done;
      logic        hit;
      logic [31:0] rd;
      logic [7:0]  rise;
      logic [7:0]  clr;
      int          idx;
      acc_first = psel && penable && !st_ff.pready;
      acc_done  = psel && penable && st_ff.pready;
      hit       = 1'b0;
      rd        = '0;
      rise      = '0;
      clr       = '0;
      idx       = 0;
      nxt_st    = st_ff;

      // RULE_03 configuration error causes
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_CFG_ERR] = (module_count == '0) ||
                                            (module_count > MAX_CNT) ||
                                            pk.over || bad_arrangement;
      // RULE_04 timeout causes
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_TIMEOUT] = mod_detached || mod_noise_lost ||
                                            mod_hot_swap || mod_op_error;
      // RULE_05 bus communication error
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_COMM_ERR] = replaced_mismatch || unknown_comm_error;
      // RULE_02 unused bit stays 0
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_UNUSED] = 1'b0;
      // RULE_09 empty module bus
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_NO_MODULE] = (module_count == '0);
      // RULE_06 warranty flag
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_WARRANTY] = warranty_expired;
      // RULE_07 module state flag
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_MODULE_STATE] = module_state_error;
      // RULE_08 coupler state flag
      nxt_st.module_fault_led_lo[cdo_pkg::BIT_COUPLER] = coupler_init_error || network_conn_error;

      // RULE_07 fault led follows
      nxt_st.mfault_led = nxt_st.module_fault_led_lo[cdo_pkg::BIT_MODULE_STATE];
      // RULE_08 system led follows
      nxt_st.sys_led    = nxt_st.module_fault_led_lo[cdo_pkg::BIT_COUPLER];

      // RULE_01 image refreshed every cycle
      nxt_st.image   = pk.image;
      nxt_st.img_len = pk.len;
      nxt_st.img_rd_byte = (int'(img_rd_index) < IMG_BYTES) ?
                           st_ff.image[img_rd_index] : cdo_pkg::BYTE_ZERO;

      // first access cycle: decode and capture the answer, pready one cycle later
      if (acc_first) begin
         nxt_st.pready = 1'b1;
         if (paddr[1:0] == cdo_pkg::WORD_ALIGN) begin
            if (paddr == cdo_pkg::OFS_MODULE_FAULT_LED) begin
               hit = 1'b1;
               // RULE_02 reserved high byte
               rd  = {16'h0000, cdo_pkg::MODULE_FAULT_LED_RESERVED_HI, st_ff.module_fault_led_lo};
            end else if (paddr == cdo_pkg::OFS_IRQ_STATUS) begin
               hit = 1'b1;
               rd  = {24'h000000, st_ff.irq_status};
            end else if (paddr == cdo_pkg::OFS_IRQ_MASK) begin
               hit = 1'b1;
               rd  = {24'h000000, st_ff.irq_mask};
            end else if (paddr == cdo_pkg::OFS_WARRANTY) begin
               hit = 1'b1;
               rd  = 32'(op_count);
            end else if (paddr == cdo_pkg::OFS_IMG_LEN) begin
               hit = 1'b1;
               rd  = {24'h000000, st_ff.img_len};
            end else if (in_region(paddr, cdo_pkg::OFS_SLOT_TYPE, MAX_SLOTS)) begin
               hit = 1'b1;
               idx = region_index(paddr, cdo_pkg::OFS_SLOT_TYPE);
               rd  = {30'h0, st_ff.slot_type[idx]};
            end else if (in_region(paddr, cdo_pkg::OFS_SLOT_DATA, MAX_SLOTS)) begin
               hit = 1'b1;
               idx = region_index(paddr, cdo_pkg::OFS_SLOT_DATA);
               rd  = st_ff.slot_data[idx];
            end else if (in_region(paddr, cdo_pkg::OFS_IMAGE, IMG_WORDS)) begin
               hit = 1'b1;
               idx = region_index(paddr, cdo_pkg::OFS_IMAGE);
               // lowest image byte of the word sits in the top lane
               rd  = {st_ff.image[idx*4], st_ff.image[idx*4+1],
                      st_ff.image[idx*4+2], st_ff.image[idx*4+3]};
            end
         end
         nxt_st.pslverr = !hit;
         nxt_st.prdata  = (hit && !pwrite) ? rd : '0;
      end

      // completing edge: writes land, status read clears what was returned
      if (acc_done) begin
         nxt_st.pready  = 1'b0;
         nxt_st.pslverr = 1'b0;
         if (!st_ff.pslverr) begin
            if (pwrite) begin
               if (paddr == cdo_pkg::OFS_IRQ_MASK) begin
                  nxt_st.irq_mask = pwdata[7:0] & cdo_pkg::EVENT_MASK;
               end else if (in_region(paddr, cdo_pkg::OFS_SLOT_TYPE, MAX_SLOTS)) begin
                  idx = region_index(paddr, cdo_pkg::OFS_SLOT_TYPE);
                  nxt_st.slot_type[idx] = pwdata[1:0];
               end else if (in_region(paddr, cdo_pkg::OFS_SLOT_DATA, MAX_SLOTS)) begin
                  idx = region_index(paddr, cdo_pkg::OFS_SLOT_DATA);
                  nxt_st.slot_data[idx] = pwdata;
               end
            end else if (paddr == cdo_pkg::OFS_IRQ_STATUS) begin
               // only bits already returned are cleared, so a later event survives
               clr = st_ff.prdata[7:0];
            end
         end
      end

      // rising flag edges are events; set wins over a clear in the same cycle
      rise = nxt_st.module_fault_led_lo & ~st_ff.module_fault_led_lo & cdo_pkg::EVENT_MASK;
      nxt_st.irq_status = (st_ff.irq_status & ~clr) | rise;
      nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign prdata           = st_ff.prdata;
   assign pready           = st_ff.pready;
   assign pslverr          = st_ff.pslverr;
   assign img_rd_byte      = st_ff.img_rd_byte;
   assign img_len          = st_ff.img_len;
   assign module_fault_led = st_ff.mfault_led;
   assign system_led       = st_ff.sys_led;
   assign irq              = st_ff.irq;

endmodule

`default_nettype wire

// ### verif/cdo_monitor.sv
// assertion checker for the coupler diagnostic block
`timescale 1ns/1ps
`default_nettype none
module cdo_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  module_count,
   input wire logic        bad_arrangement,
   input wire logic        mod_detached,
   input wire logic        mod_noise_lost,
   input wire logic        mod_hot_swap,
   input wire logic        mod_op_error,
   input wire logic        replaced_mismatch,
   input wire logic        unknown_comm_error,
   input wire logic        module_state_error,
   input wire logic        coupler_init_error,
   input wire logic        network_conn_error,
   input wire logic        module_fault_led,
   input wire logic        system_led,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a module_fault_led read completes; flags seen there were captured two edges back
   logic rd_module_fault_led;
   assign rd_module_fault_led = pready && !pwrite && paddr == cdo_pkg::OFS_MODULE_FAULT_LED;
   a_ready_one_cycle: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse_once: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_module_fault_led_reserved_zero: assert property (
      rd_module_fault_led |-> prdata[15:8] == 8'h00 && !prdata[3]) else $error("reserved bits set");
   a_cfg_error_flag: assert property (
      rd_module_fault_led && $past(module_count == 4'h0 || bad_arrangement, 2) |-> prdata[0])
      else $error("config flag missing");
   a_timeout_flag: assert property (rd_module_fault_led |-> prdata[1] ==
      $past(mod_detached || mod_noise_lost || mod_hot_swap || mod_op_error, 2))
      else $error("timeout flag wrong");
   a_comm_err_flag: assert property (
      rd_module_fault_led |-> prdata[2] == $past(replaced_mismatch || unknown_comm_error, 2))
      else $error("comm flag wrong");
   a_empty_bus_flag: assert property (
      rd_module_fault_led |-> prdata[4] == $past(module_count == 4'h0, 2)) else $error("empty flag wrong");
   // leds load at the same edge as their flag, one edge after the input
   a_fault_led_follow: assert property (
      module_fault_led == $past(module_state_error, 1)) else $error("fault led wrong");
   a_system_led_follow: assert property (
      system_led == $past(coupler_init_error || network_conn_error, 1))
      else $error("system led wrong");
   c_cfg_read: cover property (rd_module_fault_led && prdata[0]);
   c_irq_up: cover property ($rose(irq));
   c_bus_err: cover property (pslverr);
endmodule
bind cdo_top cdo_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .module_count, .bad_arrangement, .mod_detached,
   .mod_noise_lost, .mod_hot_swap, .mod_op_error, .replaced_mismatch, .unknown_comm_error,
   .module_state_error, .coupler_init_error, .network_conn_error, .module_fault_led,
   .system_led, .irq);
`default_nettype wire

// ### verif/cdo_backplane.sv
// behavioural model of the io modules on the backplane
`timescale 1ns/1ps
`default_nettype none
module cdo_backplane (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] cnt_req,
   input  wire logic [9:0] fault_req,
   input  wire logic       tick_en,
   output logic [3:0]      module_count,
   output logic [9:0]      fault,
   output logic            op_tick
);
   logic [1:0] div;
   // modules report a clock late; a time unit passes every fourth clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_count <= 4'h0;
         fault <= 10'h000;
         op_tick <= 1'b0;
         div <= 2'h0;
      end else begin
         module_count <= cnt_req;
         fault <= fault_req;
         div <= tick_en ? div + 2'h1 : 2'h0;
         op_tick <= tick_en && div == 2'h3;
      end
   end
endmodule
`default_nettype wire

// ### verif/cdo_top_tb.sv
// self-checking bench for the coupler diagnostic block
`timescale 1ns/1ps
`default_nettype none
module cdo_top_tb;
   localparam int LIM = 5;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0]  img_rd_index = 8'h00;
   logic [3:0]  cnt_req = 4'h0;
   logic [9:0]  fault_req = 10'h000;
   logic        tick_en = 1'b0;
   logic        pready, pslverr, module_fault_led, system_led, irq, op_tick, er;
   logic [7:0]  img_rd_byte, img_len;
   logic [3:0]  module_count;
   logic [9:0]  flt;
   logic [31:0] prdata, rd, sd[8];
   logic [1:0]  st[8];
   logic [7:0]  q[$];
   int          fails = 0;
   int          cmp_count = 0;
   int          wcnt = 0;
   cdo_top #(.WARRANTY_LIMIT(LIM)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .module_count, .bad_arrangement(flt[0]),
      .mod_detached(flt[1]), .mod_noise_lost(flt[2]), .mod_hot_swap(flt[3]),
      .mod_op_error(flt[4]), .replaced_mismatch(flt[5]), .unknown_comm_error(flt[6]),
      .module_state_error(flt[7]), .coupler_init_error(flt[8]),
      .network_conn_error(flt[9]), .op_tick, .img_rd_index, .img_rd_byte, .img_len,
      .module_fault_led, .system_led, .irq);
   cdo_backplane u_bp (.pclk, .presetn, .cnt_req, .fault_req, .tick_en, .module_count,
      .fault(flt), .op_tick);
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // operating units elapsed, as the model counts them
   always @(posedge pclk) begin
      if (op_tick === 1'b1) wcnt++;
   end
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_word(logic [31:0] g, logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_pin(logic [7:0] g, logic [7:0] e);
      chk_word({24'h0, g}, {24'h0, e});
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no own limit: a slave that never answers is caught by the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] exp_module_fault_led(int c, logic [9:0] f);
      logic [7:0] d;
      d = 8'h00;
      d[0] = c == 0 || c > 8 || q.size() > 16 || f[0];
      d[1] = |f[4:1];
      d[2] = |f[6:5];
      d[4] = c == 0;
      d[5] = wcnt > LIM;
      d[6] = f[7];
      d[7] = |f[9:8];
      return d;
   endfunction
   // image model, analog high byte first
   task automatic build(int c);
      q.delete();
      for (int i = 0; i < c && i < 8; i++) begin
         if (st[i] == 2'h0) q.push_back({4'h0, sd[i][3:0]});
         else if (st[i] == 2'h1) q.push_back(sd[i][7:0]);
         else begin
            q.push_back(sd[i][15:8]);
            q.push_back(sd[i][7:0]);
         end
         if (st[i] == 2'h3) q.push_back(sd[i][31:24]);
         if (st[i] == 2'h3) q.push_back(sd[i][23:16]);
      end
   endtask
   // image word w as the bus returns it, lowest byte in the top lane
   function automatic logic [31:0] img_word(int w);
      logic [31:0] v;
      v = 32'h0;
      for (int b = 0; b < 4; b++) begin
         if (4 * w + b < q.size()) v[31 - 8 * b -: 8] = q[4 * w + b];
      end
      return v;
   endfunction
   task automatic chk_module_fault_led();
      repeat (3) @(posedge pclk);
      apb(1'b0, cdo_pkg::OFS_MODULE_FAULT_LED, 32'h0);
      chk_word(rd, {24'h0, exp_module_fault_led(cnt_req, fault_req)});
      chk_pin({7'h0, module_fault_led}, {7'h0, fault_req[7]});
      chk_pin({7'h0, system_led}, {7'h0, |fault_req[9:8]});
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      final_report();
   end
   initial begin
      int c;
      c = $urandom(32'h086e);
      st = '{default: 2'h0};
      sd = '{default: 32'h0};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk_module_fault_led();
      apb(1'b0, 8'h0c, 32'h0);
      chk_pin({7'h0, er}, 8'h01);
      $display("reset test done");
      // count boundaries, then every fault cause alone
      foreach (sd[k]) begin
         c = k == 0 ? 0 : k == 1 ? 8 : k == 2 ? 9 : 1;
         cnt_req <= 4'(c);
         fault_req <= k < 3 ? 10'h000 : 10'h001 << (k - 3);
         build(c);
         chk_module_fault_led();
      end
      for (int i = 5; i < 10; i++) begin
         fault_req <= 10'h001 << i;
         chk_module_fault_led();
      end
      $display("flag test done");
      // masked and unmasked events, read clear
      fault_req <= 10'h000;
      chk_module_fault_led();
      apb(1'b0, cdo_pkg::OFS_IRQ_STATUS, 32'h0);
      apb(1'b1, cdo_pkg::OFS_IRQ_MASK, 32'hff);
      apb(1'b0, cdo_pkg::OFS_IRQ_MASK, 32'h0);
      chk_word(rd, 32'hf7);
      apb(1'b1, cdo_pkg::OFS_IRQ_MASK, 32'h02);
      fault_req <= 10'h002;
      chk_module_fault_led();
      chk_pin({7'h0, irq}, 8'h01);
      fault_req <= 10'h022;
      chk_module_fault_led();
      apb(1'b0, cdo_pkg::OFS_IRQ_STATUS, 32'h0);
      chk_word(rd, 32'h06);
      repeat (3) @(posedge pclk);
      chk_pin({7'h0, irq}, 8'h00);
      fault_req <= 10'h000;
      $display("interrupt test done");
      // random slot layouts, some overflowing the image
      for (int r = 0; r < 4; r++) begin
         c = 1 + $urandom % 6;
         for (int i = 0; i < c; i++) begin
            st[i] = 2'($urandom);
            sd[i] = $urandom;
            apb(1'b1, cdo_pkg::OFS_SLOT_TYPE + 8'(4 * i), {30'h0, st[i]});
            apb(1'b1, cdo_pkg::OFS_SLOT_DATA + 8'(4 * i), sd[i]);
         end
         cnt_req <= 4'(c);
         build(c);
         chk_module_fault_led();
         chk_pin(img_len, 8'(q.size()));
         // the first image word on the bus and the image length must agree with the model
         apb(1'b0, cdo_pkg::OFS_IMAGE, 32'h0);
         chk_word(rd, img_word(0));
         apb(1'b0, cdo_pkg::OFS_IMG_LEN, 32'h0);
         chk_word(rd, 32'(q.size()));
         for (int i = 0; i < q.size() && i < 16; i++) begin
            img_rd_index <= 8'(i);
            repeat (3) @(posedge pclk);
            chk_pin(img_rd_byte, q[i]);
         end
      end
      $display("image test done");
      // operating count crosses the limit on the second burst
      for (int r = 0; r < 2; r++) begin
         tick_en <= 1'b1;
         repeat (14) @(posedge pclk);
         tick_en <= 1'b0;
         apb(1'b0, cdo_pkg::OFS_WARRANTY, 32'h0);
         chk_word(rd, 32'(wcnt > LIM ? LIM + 1 : wcnt));
         chk_module_fault_led();
      end
      $display("warranty test done");
      final_report();
   end
endmodule
`default_nettype wire
